// File: design/pcc_clock_ctrl.sv
// Clock controller: control/status, multiplier and divider registers, clock selection
`timescale 1ns/1ps
`include "pcc_defs.svh"
module pcc_clock_ctrl (
   input  wire logic                clk_i,
   input  wire logic                resetn_i,
   input  wire logic                ce_i,
   input  wire logic [31:0]         reg_addr_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   input  wire logic [31:0]         reg_wdata_i,
   output logic      [31:0]         reg_rdata_o,
   input  wire logic                ref_clock_in_i,
   input  wire logic                pll_output_clock_i,
   input  wire logic                ext_mem_clock_in_i,
   input  wire logic                mem_clock_source_select_i,
   output logic                     pll_reset_ctl_o,
   output logic                     pll_power_down_o,
   output pcc_pkg::pcc_ratio_t      pll_multiplier_o,
   output pcc_pkg::pcc_ratio_t      prescale_divider_o,
   output logic                     core_clock_o,
   output logic                     periph_bus_clock_o,
   output logic                     bus_clock_out_pin_o,
   output logic                     ext_mem_clock_o
);
   import pcc_pkg::*;

   function automatic logic any_edge(input logic cur, input logic prev);
      any_edge = cur ^ prev;
   endfunction

   function automatic logic [31:0] div_word(input logic en, input pcc_ratio_t r);
      div_word = 32'h0000_0000;
      div_word[`PCC_DIV_EN_BIT] = en;
      div_word[4:0] = r;
   endfunction

   logic [2:0] ref_s_r, pll_s_r;
   logic [1:0] msel_s_r, ext_s_r;
   logic       path_sel_r, pwrdn_r, rst_r;
   pcc_ratio_t mult_r, div0_r, div1_r, div2_r, div3_r;
   logic       en0_r, en1_r, en2_r, en3_r;
   logic       src_sel_r, mem_sel_r;
   pcc_osc_t   osc_state_r;
   logic [11:0] osc_cnt_r;
   logic       ref_tick, pll_tick, src_tick, wr_ok, rd_ok;
   logic [31:0] rdata_nxt;

   pcc_div_if core_if ();
   pcc_div_if bus_if ();
   pcc_div_if mem_if ();

   // Pins pass two flops; the third stage only feeds edge detection
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ref_s_r  <= 3'h0;
         pll_s_r  <= 3'h0;
         ext_s_r  <= 2'h0;
         msel_s_r <= 2'h0;
      end else if (ce_i) begin
         ref_s_r  <= {ref_s_r[1:0], ref_clock_in_i};
         pll_s_r  <= {pll_s_r[1:0], pll_output_clock_i};
         ext_s_r  <= {ext_s_r[0], ext_mem_clock_in_i};
         msel_s_r <= {msel_s_r[0], mem_clock_source_select_i};
      end
   end

   assign ref_tick = any_edge(ref_s_r[1], ref_s_r[2]);
   assign pll_tick = any_edge(pll_s_r[1], pll_s_r[2]);
   assign src_tick = src_sel_r ? pll_tick : ref_tick;
   assign wr_ok    = ce_i && reg_wr_i;
   assign rd_ok    = ce_i && reg_rd_i;

   // Control/status writes; reserved bits are never stored
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         path_sel_r <= 1'b0;
         pwrdn_r    <= 1'b0;
         rst_r      <= 1'b1;
      end else if (wr_ok && reg_addr_i == `PCC_ADDR_CSR) begin
         path_sel_r <= reg_wdata_i[`PCC_CSR_PATH_BIT];
         pwrdn_r    <= reg_wdata_i[`PCC_CSR_PWRDN_BIT];
         rst_r      <= reg_wdata_i[`PCC_CSR_RST_BIT];
      end
   end

   // Multiplier and dividers accept writes whenever the core runs
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mult_r <= `PCC_MULT_RST;
         div0_r <= `PCC_DIV0_RST;
         div1_r <= `PCC_DIV1_RST;
         div2_r <= `PCC_DIV2_RST;
         div3_r <= `PCC_DIV3_RST;
         en0_r  <= 1'b1;
         en1_r  <= 1'b1;
         en2_r  <= 1'b1;
         en3_r  <= 1'b1;
      end else if (wr_ok) begin
         case (reg_addr_i)
            `PCC_ADDR_MULT: mult_r <= reg_wdata_i[4:0];
            `PCC_ADDR_DIV0: begin
               div0_r <= reg_wdata_i[4:0];
               en0_r  <= reg_wdata_i[`PCC_DIV_EN_BIT];
            end
            `PCC_ADDR_DIV1: begin
               div1_r <= reg_wdata_i[4:0];
               en1_r  <= reg_wdata_i[`PCC_DIV_EN_BIT];
            end
            `PCC_ADDR_DIV2: begin
               div2_r <= reg_wdata_i[4:0];
               en2_r  <= reg_wdata_i[`PCC_DIV_EN_BIT];
            end
            `PCC_ADDR_DIV3: begin
               div3_r <= reg_wdata_i[4:0];
               en3_r  <= reg_wdata_i[`PCC_DIV_EN_BIT];
            end
            default: ;
         endcase
      end
   end

   // Oscillator stabilisation: counts reference rising edges after every reset
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         osc_state_r <= PCC_OSC_WAIT;
         osc_cnt_r   <= 12'h000;
      end else if (ce_i) begin
         case (osc_state_r)
            PCC_OSC_WAIT: begin
               if (ref_tick && ref_s_r[1]) begin
                  if (osc_cnt_r == `PCC_STABLE_COUNT - 12'h001) begin
                     osc_state_r <= PCC_OSC_STABLE;
                  end else begin
                     osc_cnt_r <= osc_cnt_r + 12'h001;
                  end
               end
            end
            PCC_OSC_STABLE: osc_state_r <= PCC_OSC_STABLE;
            default: osc_state_r <= PCC_OSC_WAIT;
         endcase
      end
   end

   // Source changes only at a core period boundary or while the core divider is disabled; the bus and memory dividers can be mid-phase at the switch
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         src_sel_r <= 1'b0;
      end else if (ce_i && (core_if.wrap || !en1_r)) begin
         src_sel_r <= path_sel_r;
      end
   end

   // Memory clock source swaps only while both candidates are low
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         mem_sel_r <= 1'b0;
      end else if (ce_i && !ext_s_r[1] && !mem_if.q) begin
         mem_sel_r <= msel_s_r[1];
      end
   end

   assign core_if.tick  = src_tick;
   assign core_if.ratio = div1_r;
   assign core_if.en    = en1_r;
   assign bus_if.tick   = src_tick;
   assign bus_if.ratio  = div2_r;
   assign bus_if.en     = en2_r;
   assign mem_if.tick   = src_tick;
   assign mem_if.ratio  = div3_r;
   assign mem_if.en     = en3_r;

   pcc_divider #(.RST_RATIO(`PCC_DIV1_RST)) u_core_div (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .d        (core_if.div)
   );
   pcc_divider #(.RST_RATIO(`PCC_DIV2_RST)) u_bus_div (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .d        (bus_if.div)
   );
   pcc_divider #(.RST_RATIO(`PCC_DIV3_RST)) u_mem_div (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ce_i     (ce_i),
      .d        (mem_if.div)
   );

   // Bus clock and its pin share one flop so they can never skew apart
   assign periph_bus_clock_o  = bus_if.q;
   assign bus_clock_out_pin_o = bus_if.q;
   assign core_clock_o        = core_if.q;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         ext_mem_clock_o <= 1'b0;
      end else if (ce_i) begin
         ext_mem_clock_o <= mem_sel_r ? ext_s_r[1] : mem_if.q;
      end
   end

   // PLL macro controls, registered once; the prescaler output holds its reset value while its enable bit is low
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         pll_reset_ctl_o    <= 1'b1;
         pll_power_down_o   <= 1'b0;
         pll_multiplier_o   <= `PCC_MULT_RST;
         prescale_divider_o <= `PCC_DIV0_RST;
      end else if (ce_i) begin
         pll_reset_ctl_o    <= rst_r;
         pll_power_down_o   <= pwrdn_r;
         pll_multiplier_o   <= mult_r;
         prescale_divider_o <= en0_r ? div0_r : `PCC_DIV0_RST;
      end
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (reg_addr_i)
         `PCC_ADDR_CSR: begin
            rdata_nxt[`PCC_CSR_STABLE_BIT] = (osc_state_r == PCC_OSC_STABLE);
            rdata_nxt[`PCC_CSR_RST_BIT]    = rst_r;
            rdata_nxt[`PCC_CSR_PWRDN_BIT]  = pwrdn_r;
            rdata_nxt[`PCC_CSR_PATH_BIT]   = path_sel_r;
         end
         `PCC_ADDR_MULT: rdata_nxt[4:0] = mult_r;
         `PCC_ADDR_DIV0: rdata_nxt = div_word(en0_r, div0_r);
         `PCC_ADDR_DIV1: rdata_nxt = div_word(en1_r, div1_r);
         `PCC_ADDR_DIV2: rdata_nxt = div_word(en2_r, div2_r);
         `PCC_ADDR_DIV3: rdata_nxt = div_word(en3_r, div3_r);
         default: rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (rd_ok) begin
         reg_rdata_o <= rdata_nxt;
      end
   end

   property p_stable_after_count;
      @(posedge clk_i) disable iff (!resetn_i)
      $changed(osc_state_r) && $past(resetn_i)
         |-> $past(osc_cnt_r) == `PCC_STABLE_COUNT - 12'h001;
   endproperty
   a_stable_after_count: assert property (p_stable_after_count)
      else $error("Stable reported before the count ended");

   property p_stable_read;
      @(posedge clk_i) disable iff (!resetn_i)
      $past(rd_ok) && $past(reg_addr_i) == `PCC_ADDR_CSR
         && $past(osc_cnt_r) != `PCC_STABLE_COUNT - 12'h001
         |-> !reg_rdata_o[`PCC_CSR_STABLE_BIT];
   endproperty
   a_stable_read: assert property (p_stable_read)
      else $error("Stable bit disagrees with the counter");

   property p_reset_default;
      @(posedge clk_i) disable iff (!resetn_i)
      !$past(resetn_i) |-> pll_reset_ctl_o && !pll_power_down_o && pll_multiplier_o == 5'h07;
   endproperty
   a_reset_default: assert property (p_reset_default)
      else $error("PLL controls wrong after reset");

   property p_pwrdn_write;
      @(posedge clk_i) disable iff (!resetn_i)
      wr_ok && reg_addr_i == `PCC_ADDR_CSR ##1 ce_i
         |=> pll_power_down_o == $past(reg_wdata_i[`PCC_CSR_PWRDN_BIT], 2);
   endproperty
   a_pwrdn_write: assert property (p_pwrdn_write)
      else $error("Power-down output does not follow write");

   property p_reserved_zero;
      @(posedge clk_i) disable iff (!resetn_i)
      rd_ok && reg_addr_i == `PCC_ADDR_CSR
         |=> reg_rdata_o[31:7] == 25'h000_0000 && reg_rdata_o[5:4] == 2'h0 && !reg_rdata_o[2];
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("Reserved status bits not zero");

   property p_mult_write;
      @(posedge clk_i) disable iff (!resetn_i)
      wr_ok && reg_addr_i == `PCC_ADDR_MULT ##1 ce_i
         |=> pll_multiplier_o == $past(reg_wdata_i[4:0], 2);
   endproperty
   a_mult_write: assert property (p_mult_write)
      else $error("Multiplier write not applied");

   property p_src_at_boundary;
      @(posedge clk_i) disable iff (!resetn_i)
      $changed(src_sel_r) && $past(resetn_i) |-> $past(core_if.wrap) || !$past(en1_r);
   endproperty
   a_src_at_boundary: assert property (p_src_at_boundary)
      else $error("Source switched mid period");

   property p_mem_onchip;
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i && !mem_sel_r |=> ext_mem_clock_o == $past(mem_if.q);
   endproperty
   a_mem_onchip: assert property (p_mem_onchip)
      else $error("Memory clock not from third divider");

   property p_mem_external;
      @(posedge clk_i) disable iff (!resetn_i)
      ce_i && mem_sel_r |=> ext_mem_clock_o == $past(ext_s_r[1]);
   endproperty
   a_mem_external: assert property (p_mem_external)
      else $error("Memory clock not from external pin");
endmodule

// File: design/pcc_divider.sv
// Glitch-free post-divider counting half periods of the selected source
`timescale 1ns/1ps
module pcc_divider #(
   parameter pcc_pkg::pcc_ratio_t RST_RATIO = 5'h00
) (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic ce_i,
   pcc_div_if.div    d
);
   import pcc_pkg::*;

   logic [4:0] cnt_r;
   pcc_ratio_t ratio_eff_r;
   logic       q_r;
   logic       wrap_r;

   assign d.q    = q_r;
   assign d.wrap = wrap_r;

   // Each half period lasts ratio+1 source half periods; a new ratio is taken only
   // at a rising output edge or while the divider is disabled, so no phase is ever cut short
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cnt_r       <= 5'h00;
         ratio_eff_r <= RST_RATIO;
         q_r         <= 1'b0;
         wrap_r      <= 1'b0;
      end else if (ce_i) begin
         wrap_r <= 1'b0;
         if (!d.en) begin
            cnt_r       <= 5'h00;
            q_r         <= 1'b0;
            ratio_eff_r <= d.ratio;
         end else if (d.tick) begin
            if (cnt_r == ratio_eff_r) begin
               cnt_r <= 5'h00;
               q_r   <= ~q_r;
               if (!q_r) begin
                  ratio_eff_r <= d.ratio;
                  wrap_r      <= 1'b1;
               end
            end else begin
               cnt_r <= cnt_r + 5'h01;
            end
         end
      end
   end

   property p_toggle_on_count;
      @(posedge clk_i) disable iff (!resetn_i)
      $changed(q_r) && $past(resetn_i) && $past(d.en)
         |-> $past(cnt_r) == $past(ratio_eff_r) && $past(d.tick);
   endproperty
   a_toggle_on_count: assert property (p_toggle_on_count)
      else $error("Divider output toggled before its count");

   property p_ratio_at_rise;
      @(posedge clk_i) disable iff (!resetn_i)
      $changed(ratio_eff_r) && $past(resetn_i) && $past(d.en) |-> $rose(q_r);
   endproperty
   a_ratio_at_rise: assert property (p_ratio_at_rise)
      else $error("Divider ratio changed mid period");
endmodule

// File: pkg/pcc_defs.svh
// Register offsets, field positions, reset values and counts of the clock controller
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH

`define PCC_ADDR_CSR       32'h01b7_c100
`define PCC_ADDR_MULT      32'h01b7_c110
`define PCC_ADDR_DIV0      32'h01b7_c114
`define PCC_ADDR_DIV1      32'h01b7_c118
`define PCC_ADDR_DIV2      32'h01b7_c11c
`define PCC_ADDR_DIV3      32'h01b7_c120

`define PCC_CSR_PATH_BIT   0
`define PCC_CSR_PWRDN_BIT  1
`define PCC_CSR_RST_BIT    3
`define PCC_CSR_STABLE_BIT 6
`define PCC_DIV_EN_BIT     15

`define PCC_MULT_RST       5'h07
`define PCC_DIV0_RST       5'h00
`define PCC_DIV1_RST       5'h00
`define PCC_DIV2_RST       5'h01
`define PCC_DIV3_RST       5'h01

// Reference rising edges counted before the input is reported stable
`define PCC_STABLE_COUNT   12'h0400

`endif

// File: pkg/pcc_div_if.sv
// Connection between the controller and one post-divider
`timescale 1ns/1ps
interface pcc_div_if;
   import pcc_pkg::*;
   logic       tick;
   pcc_ratio_t ratio;
   logic       en;
   logic       q;
   logic       wrap;
   modport ctl (output tick, output ratio, output en, input q, input wrap);
   modport div (input tick, input ratio, input en, output q, output wrap);
endinterface

// File: pkg/pcc_pkg.sv
// Types shared by the clock controller modules
package pcc_pkg;
   typedef logic [4:0] pcc_ratio_t;
   typedef enum logic [1:0] {
      PCC_OSC_WAIT   = 2'h1,
      PCC_OSC_STABLE = 2'h2
   } pcc_osc_t;
endpackage

// File: sim/tb.sv
// Self-checking testbench of the clock controller
`timescale 1ns/1ps
`include "pcc_defs.svh"
module tb;
   import pcc_pkg::*;
   localparam int HALF_REF = 4;
   localparam int HALF_PLL = 3;
   localparam int HALF_EXT = 5;
   logic        clk_i                     = 1'b0;
   logic        resetn_i                  = 1'b0;
   logic        ce_i                      = 1'b1;
   logic [31:0] reg_addr_i                = 32'h0000_0000;
   logic        reg_wr_i                  = 1'b0;
   logic        reg_rd_i                  = 1'b0;
   logic [31:0] reg_wdata_i               = 32'h0000_0000;
   logic [31:0] reg_rdata_o;
   logic        ref_clock_in_i            = 1'b0;
   logic        pll_output_clock_i        = 1'b0;
   logic        ext_mem_clock_in_i        = 1'b0;
   logic        mem_clock_source_select_i = 1'b0;
   logic        pll_reset_ctl_o;
   logic        pll_power_down_o;
   pcc_ratio_t  pll_multiplier_o;
   pcc_ratio_t  prescale_divider_o;
   logic        core_clock_o;
   logic        periph_bus_clock_o;
   logic        bus_clock_out_pin_o;
   logic        ext_mem_clock_o;
   int          fail_count = 0;
   int          num_checks = 0;
   int          ref_cnt    = 0;
   int          pll_cnt    = 0;
   int          ext_cnt    = 0;
   int          polls;
   logic [31:0] rd_val;
   logic [31:0] addr_tab [5] = '{`PCC_ADDR_MULT, `PCC_ADDR_DIV0, `PCC_ADDR_DIV1,
                                 `PCC_ADDR_DIV2, `PCC_ADDR_DIV3};
   logic [31:0] rst_tab  [5] = '{32'h0000_0007, 32'h0000_8000, 32'h0000_8000,
                                 32'h0000_8001, 32'h0000_8001};

   pcc_clock_ctrl pcc_clock_ctrl_i (
      .clk_i                     (clk_i),
      .resetn_i                  (resetn_i),
      .ce_i                      (ce_i),
      .reg_addr_i                (reg_addr_i),
      .reg_wr_i                  (reg_wr_i),
      .reg_rd_i                  (reg_rd_i),
      .reg_wdata_i               (reg_wdata_i),
      .reg_rdata_o               (reg_rdata_o),
      .ref_clock_in_i            (ref_clock_in_i),
      .pll_output_clock_i        (pll_output_clock_i),
      .ext_mem_clock_in_i        (ext_mem_clock_in_i),
      .mem_clock_source_select_i (mem_clock_source_select_i),
      .pll_reset_ctl_o           (pll_reset_ctl_o),
      .pll_power_down_o          (pll_power_down_o),
      .pll_multiplier_o          (pll_multiplier_o),
      .prescale_divider_o        (prescale_divider_o),
      .core_clock_o              (core_clock_o),
      .periph_bus_clock_o        (periph_bus_clock_o),
      .bus_clock_out_pin_o       (bus_clock_out_pin_o),
      .ext_mem_clock_o           (ext_mem_clock_o)
   );

   always #25 clk_i = ~clk_i;

   // Source clocks kept well below a quarter of the controller rate
   always @(posedge clk_i) begin
      ref_cnt <= (ref_cnt == HALF_REF - 1) ? 0 : ref_cnt + 1;
      pll_cnt <= (pll_cnt == HALF_PLL - 1) ? 0 : pll_cnt + 1;
      ext_cnt <= (ext_cnt == HALF_EXT - 1) ? 0 : ext_cnt + 1;
      if (ref_cnt == HALF_REF - 1)
         ref_clock_in_i <= ~ref_clock_in_i;
      if (pll_cnt == HALF_PLL - 1)
         pll_output_clock_i <= ~pll_output_clock_i;
      if (ext_cnt == HALF_EXT - 1)
         ext_mem_clock_in_i <= ~ext_mem_clock_in_i;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] addr, input logic [31:0] data);
      @(posedge clk_i);
      reg_addr_i  <= addr;
      reg_wdata_i <= data;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   // Read data is registered, so it is taken just after the accepting edge
   task automatic rd(input logic [31:0] addr, output logic [31:0] data);
      @(posedge clk_i);
      reg_addr_i <= addr;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      data = reg_rdata_o;
   endtask

   // Control outputs lag a register write by two edges
   task automatic outs(input logic rst, input logic pwr);
      repeat (2) @(posedge clk_i);
      #1;
      check(32'(pll_reset_ctl_o), 32'(rst));
      check(32'(pll_power_down_o), 32'(pwr));
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return core_clock_o;
         1: return periph_bus_clock_o;
         default: return ext_mem_clock_o;
      endcase
   endfunction

   // Rise-to-rise period of a clock output, after two rises to let changes settle
   task automatic period(input int sel, input int exp_per);
      logic prev;
      int   n;
      int   rises;
      n     = 0;
      rises = 0;
      #1;
      prev  = pick(sel);
      for (int i = 0; i < 3000 && rises < 3; i++) begin
         @(posedge clk_i);
         #1;
         if (rises == 2)
            n++;
         if (pick(sel) === 1'b1 && prev === 1'b0)
            rises++;
         prev = pick(sel);
         if (sel == 1)
            check(32'(bus_clock_out_pin_o), 32'(periph_bus_clock_o));
      end
      if (rises < 3) begin
         fail_count++;
         close_out();
      end
      check(32'(n), 32'(exp_per));
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(`PCC_ADDR_CSR, rd_val);
      check(rd_val, 32'h0000_0008);
      outs(1'b1, 1'b0);
      for (int k = 0; k < 5; k++) begin
         rd(addr_tab[k], rd_val);
         check(rd_val, rst_tab[k]);
      end
      check(32'(pll_multiplier_o), 32'h0000_0007);
      $display("done: reset values");
      // Reserved bits set on purpose; bit 2 kept zero, only bit 1 of the low nibble high
      wr(`PCC_ADDR_CSR, 32'hFFFF_FFF2);
      rd(`PCC_ADDR_CSR, rd_val);
      check(rd_val, 32'h0000_0002);
      outs(1'b0, 1'b1);
      wr(`PCC_ADDR_CSR, 32'h0000_0008);
      outs(1'b1, 1'b0);
      repeat (4) @(posedge clk_i);
      wr(`PCC_ADDR_CSR, 32'h0000_0000);
      outs(1'b0, 1'b0);
      wr(32'h01b7_c104, 32'hFFFF_FFFF);
      rd(32'h01b7_c104, rd_val);
      check(rd_val, 32'h0000_0000);
      rd(`PCC_ADDR_CSR, rd_val);
      check(rd_val, 32'h0000_0000);
      // Enable low: a write must leave every control untouched
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(`PCC_ADDR_CSR, 32'h0000_000A);
      ce_i <= 1'b1;
      rd(`PCC_ADDR_CSR, rd_val);
      check(rd_val, 32'h0000_0000);
      outs(1'b0, 1'b0);
      $display("done: control bits");
      // Still in bypass, so the prescaler and multiplier may change
      wr(`PCC_ADDR_MULT, 32'hFFFF_FF19);
      rd(`PCC_ADDR_MULT, rd_val);
      check(rd_val, 32'h0000_0019);
      check(32'(pll_multiplier_o), 32'h0000_0019);
      wr(`PCC_ADDR_DIV0, 32'hFFFF_7FE3);
      rd(`PCC_ADDR_DIV0, rd_val);
      check(rd_val, 32'h0000_0003);
      check(32'(prescale_divider_o), 32'h0000_0000);
      wr(`PCC_ADDR_DIV0, 32'h0000_8003);
      repeat (2) @(posedge clk_i);
      #1;
      check(32'(prescale_divider_o), 32'h0000_0003);
      wr(`PCC_ADDR_DIV0, 32'h0000_8000);
      $display("done: multiplier and prescaler");
      polls  = 0;
      rd_val = 32'h0000_0000;
      while (rd_val[6] !== 1'b1 && polls < 6000) begin
         rd(`PCC_ADDR_CSR, rd_val);
         polls++;
      end
      if (rd_val[6] !== 1'b1) begin
         fail_count++;
         close_out();
      end
      check(rd_val, 32'h0000_0040);
      $display("done: input stable after %0d polls", polls);
      // Bypass: one tick every HALF_REF cycles
      period(0, 2 * HALF_REF);
      period(1, 4 * HALF_REF);
      period(2, 4 * HALF_REF);
      wr(`PCC_ADDR_DIV2, 32'h0000_8009);
      wr(`PCC_ADDR_DIV1, 32'h0000_8004);
      period(0, 10 * HALF_REF);
      period(1, 20 * HALF_REF);
      wr(`PCC_ADDR_DIV1, 32'h0000_8000);
      wr(`PCC_ADDR_DIV2, 32'h0000_8001);
      period(0, 2 * HALF_REF);
      period(1, 4 * HALF_REF);
      $display("done: divider changes");
      @(posedge clk_i);
      mem_clock_source_select_i <= 1'b1;
      period(2, 2 * HALF_EXT);
      @(posedge clk_i);
      mem_clock_source_select_i <= 1'b0;
      $display("done: memory clock source");
      // PLL reset was released long before the stable poll ended, past the lock time
      wr(`PCC_ADDR_CSR, 32'h0000_0001);
      period(0, 2 * HALF_PLL);
      period(1, 4 * HALF_PLL);
      period(2, 4 * HALF_PLL);
      wr(`PCC_ADDR_CSR, 32'h0000_0000);
      period(0, 2 * HALF_REF);
      $display("done: path select");
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (6) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(`PCC_ADDR_CSR, rd_val);
      check(rd_val, 32'h0000_0008);
      rd(`PCC_ADDR_MULT, rd_val);
      check(rd_val, 32'h0000_0007);
      $display("done: second reset");
      close_out();
   end
endmodule
